/* File: sebs_map.vh */
// Constants for the serial EEPROM two-wire slave front end.
`ifndef SEBS_MAP_VH
`define SEBS_MAP_VH
`define SEBS_DEV_ADDR 7'h50
`define SEBS_RW_READ 1'h1
`define SEBS_BITS_PER_BYTE 4'h8
`define SEBS_PAGE_BYTES 4'h8
`define SEBS_MEM_WORDS 128
`define SEBS_PTR_RESET 7'h00
`define SEBS_BIT_RESET 4'h0
`define SEBS_SYNC_IDLE 4'hF
// Twenty milliseconds of programming time at the 100 MHz clock.
`define SEBS_PROG_CYCLES 21'h1E8480
`define SEBS_PROG_CNT_W 21
`endif

/* File: sebs_sync.v */
// Two-flop synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ps
module sebs_sync #(
   parameter W = 4,
   parameter [W-1:0] RST = {W{1'b1}}
) (
   // Clock and reset.
   input wire clk,
   input wire resetn,
   // Data.
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_reg;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= RST;
         q <= RST;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule // sebs_sync

/* File: sebs_buf2.v */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sebs_buf2 #(
   parameter W = 8
) (
   // Clock and reset.
   input wire clk,
   input wire resetn,
   input wire flush,
   // Filling side.
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Draining side.
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] slot0_reg;
   reg [W-1:0] slot1_reg;
   reg [1:0] cnt_reg;
   wire push;
   wire pop;

   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = slot0_reg;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slot0_reg <= {W{1'b0}};
         slot1_reg <= {W{1'b0}};
         cnt_reg <= 2'h0;
      end else if (flush) begin
         cnt_reg <= 2'h0;
      end else if (push && pop) begin
         if (cnt_reg == 2'h1) begin
            slot0_reg <= in_data;
         end else begin
            slot0_reg <= slot1_reg;
            slot1_reg <= in_data;
         end
      end else if (push) begin
         if (cnt_reg == 2'h0) begin
            slot0_reg <= in_data;
         end else begin
            slot1_reg <= in_data;
         end
         cnt_reg <= cnt_reg + 2'h1;
      end else if (pop) begin
         slot0_reg <= slot1_reg;
         cnt_reg <= cnt_reg - 2'h1;
      end
   end
endmodule // sebs_buf2

/* File: sebs_top.v */
// Two-wire slave front end of a 128-byte serial EEPROM with transmit-only mode.
//
// What this block does
// - Write transaction buffers at most eight bytes.
// - Reads within one transaction are unlimited.
// - Acknowledge each received byte on ninth clock, except write data past the eighth byte.
// - No acknowledge while programming; SDA released.
// - Master's missing acknowledge ends read; release SDA.
// - Match address 1010000 after every START.
// - Eighth address bit: one reads, zero writes.
// - First write byte loads pointer; then data.
// - STOP after write data starts programming cycle.
// - Data held in page buffer until STOP.
// - Writes increment only three low pointer bits; reads increment all seven.
// - Protect input low blocks all memory writes.
// - Protect input ignored in transmit-only mode.
// - Pointer holds last accessed location plus one.
// - Read sends words from pointer until nack.
// - Repeated START abandons write, keeps new pointer.
// - Master acknowledge advances to next word.
// - In bidirectional mode, SDA changes only while SCL is low.
// - SCL falling edge enters bidirectional mode.
// - Legacy clock rising edge shifts transmit-only bits.
// - SDA only pulled low or released.
// - Array of 128 eight-bit bytes.
// - Bidirectional mode held until resetn goes low.
`timescale 1ns/1ps
`include "sebs_map.vh"
module sebs_top #(
   parameter [`SEBS_PROG_CNT_W-1:0] PROG_CYCLES = `SEBS_PROG_CYCLES
) (
   // Clock and reset.
   input wire mclk,
   input wire resetn,
   // Two-wire bus pins.
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Legacy clock and write protect.
   input wire legacy_tx_clock,
   input wire write_protect_n,
   // Status.
   output reg bidirectional_mode,
   output reg prog_busy
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DEV = 3'h1;
   localparam [2:0] ST_WORD = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_RDATA = 3'h4;

   ////////////////////////////////////////////////////////////////////////////////
   reg [7:0] mem [0:`SEBS_MEM_WORDS-1];
   reg [7:0] pbuf [0:`SEBS_PAGE_BYTES-1];
   reg [`SEBS_PAGE_BYTES-1:0] pvalid_reg;
   wire [3:0] sync_q;
   wire scl_s;
   wire sda_s;
   wire ltx_clk_s;
   wire wp_n_s;
   reg scl_d_reg;
   reg sda_d_reg;
   reg ltx_clk_d_reg;
   reg [2:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg in_ack_reg;
   reg rw_reg;
   reg acked_reg;
   reg master_ack_reg;
   reg [7:0] shift_in_reg;
   reg [7:0] tx_shift_reg;
   reg [6:0] ptr_reg;
   reg [6:0] fetch_ptr_reg;
   reg fetch_en_reg;
   reg [3:0] wr_cnt_reg;
   reg [`SEBS_PROG_CNT_W-1:0] prog_cnt_reg;
   reg [6:0] tptr_reg;
   reg [3:0] tbit_reg;
   wire scl_rise;
   wire scl_fall;
   wire ltx_clk_rise;
   wire start_det;
   wire stop_det;
   wire byte_done;
   wire ack_end;
   wire addr_match;
   wire tx_load;
   wire do_commit;
   wire store_byte;
   wire flush;
   wire push_ok;
   wire buf_in_ready;
   wire buf_out_valid;
   wire [7:0] buf_out_data;
   wire [7:0] tdata;

   ////////////////////////////////////////////////////////////////////////////////
   // Every pin passes two flops; the bus lines idle high.
   sebs_sync #(.W(4), .RST(`SEBS_SYNC_IDLE)) u_sync (
      .clk(mclk),
      .resetn(resetn),
      .d({scl_in, sda_in, legacy_tx_clock, write_protect_n}),
      .q(sync_q)
   );
   assign scl_s = sync_q[3];
   assign sda_s = sync_q[2];
   assign ltx_clk_s = sync_q[1];
   assign wp_n_s = sync_q[0];

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         ltx_clk_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         ltx_clk_d_reg <= ltx_clk_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign ltx_clk_rise = ltx_clk_s & ~ltx_clk_d_reg;
   // In bidirectional mode, a data change while SCL is high is a START or STOP, never data.
   assign start_det = bidirectional_mode & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_det = bidirectional_mode & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   assign byte_done = scl_fall & ~in_ack_reg & (bit_cnt_reg == `SEBS_BITS_PER_BYTE);
   assign ack_end = scl_fall & in_ack_reg;
   assign addr_match = (shift_in_reg[7:1] == `SEBS_DEV_ADDR) & ~prog_busy;
   assign tx_load = ack_end & ((state_reg == ST_DEV & rw_reg & acked_reg) |
                    (state_reg == ST_RDATA & master_ack_reg));
   assign store_byte = byte_done & (state_reg == ST_WDATA) & (wr_cnt_reg < `SEBS_PAGE_BYTES);
   // Protected writes and bare address writes never start a cycle.
   assign do_commit = stop_det & (state_reg == ST_WDATA) & (wr_cnt_reg != 4'h0)
                      & wp_n_s & ~start_det;
   assign flush = byte_done & (state_reg == ST_DEV) & addr_match
                  & (shift_in_reg[0] == `SEBS_RW_READ);
   assign push_ok = fetch_en_reg & buf_in_ready & ~flush;

   ////////////////////////////////////////////////////////////////////////////////
   // Read words are fetched ahead so a slow shift-out loses nothing.
   sebs_buf2 #(.W(8)) u_rbuf (
      .clk(mclk),
      .resetn(resetn),
      .flush(flush),
      .in_valid(push_ok),
      .in_ready(buf_in_ready),
      .in_data(mem[fetch_ptr_reg]),
      .out_valid(buf_out_valid),
      .out_ready(tx_load),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // The array and page buffer carry no reset, as a real array would not.
   always @(posedge mclk) begin : mem_wr
      integer i;
      if (store_byte) begin
         pbuf[ptr_reg[2:0]] <= shift_in_reg;
      end
      if (do_commit) begin
         for (i = 0; i < `SEBS_PAGE_BYTES; i = i + 1) begin
            if (pvalid_reg[i]) begin
               mem[{ptr_reg[6:3], i[2:0]}] <= pbuf[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Self-timed programming cycle.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prog_busy <= 1'b0;
         prog_cnt_reg <= {`SEBS_PROG_CNT_W{1'b0}};
      end else if (do_commit) begin
         prog_busy <= 1'b1;
         prog_cnt_reg <= PROG_CYCLES - 1'b1;
      end else if (prog_busy) begin
         if (prog_cnt_reg == {`SEBS_PROG_CNT_W{1'b0}}) begin
            prog_busy <= 1'b0;
         end else begin
            prog_cnt_reg <= prog_cnt_reg - 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign tdata = mem[tptr_reg];

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         bidirectional_mode <= 1'b0;
         state_reg <= ST_IDLE;
         bit_cnt_reg <= `SEBS_BIT_RESET;
         in_ack_reg <= 1'b0;
         rw_reg <= 1'b0;
         acked_reg <= 1'b0;
         master_ack_reg <= 1'b0;
         shift_in_reg <= 8'h00;
         tx_shift_reg <= 8'h00;
         ptr_reg <= `SEBS_PTR_RESET;
         fetch_ptr_reg <= `SEBS_PTR_RESET;
         fetch_en_reg <= 1'b0;
         wr_cnt_reg <= 4'h0;
         pvalid_reg <= {`SEBS_PAGE_BYTES{1'b0}};
         tptr_reg <= `SEBS_PTR_RESET;
         tbit_reg <= `SEBS_BIT_RESET;
      end else if (!bidirectional_mode) begin
         // Transmit-only mode; the protect pin has no path here.
         if (scl_fall) begin
            bidirectional_mode <= 1'b1;
            sda_oe <= 1'b0;
         end else if (ltx_clk_rise) begin
            if (tbit_reg == `SEBS_BITS_PER_BYTE) begin
               sda_oe <= 1'b0;
               tbit_reg <= `SEBS_BIT_RESET;
               tptr_reg <= tptr_reg + 7'h01;
            end else begin
               sda_oe <= ~tdata[3'h7 - tbit_reg[2:0]];
               tbit_reg <= tbit_reg + 4'h1;
            end
         end
      end else begin
         // Only reset clears the mode flag; no path here does.
         if (push_ok) begin
            fetch_ptr_reg <= fetch_ptr_reg + 7'h01;
         end
         if (start_det) begin
            state_reg <= ST_DEV;
            bit_cnt_reg <= `SEBS_BIT_RESET;
            in_ack_reg <= 1'b0;
            wr_cnt_reg <= 4'h0;
            pvalid_reg <= {`SEBS_PAGE_BYTES{1'b0}};
            fetch_en_reg <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_det) begin
            state_reg <= ST_IDLE;
            fetch_en_reg <= 1'b0;
            sda_oe <= 1'b0;
         end else if (state_reg != ST_IDLE) begin
            if (scl_rise) begin
               if (in_ack_reg) begin
                  master_ack_reg <= ~sda_s;
               end else if (bit_cnt_reg != `SEBS_BITS_PER_BYTE) begin
                  shift_in_reg <= {shift_in_reg[6:0], sda_s};
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end
            end else if (byte_done) begin
               in_ack_reg <= 1'b1;
               case (state_reg)
                  ST_DEV: begin
                     if (addr_match) begin
                        sda_oe <= 1'b1;
                        acked_reg <= 1'b1;
                        rw_reg <= shift_in_reg[0];
                        if (shift_in_reg[0] == `SEBS_RW_READ) begin
                           fetch_ptr_reg <= ptr_reg;
                           fetch_en_reg <= 1'b1;
                        end
                     end else begin
                        state_reg <= ST_IDLE;
                        in_ack_reg <= 1'b0;
                        sda_oe <= 1'b0;
                     end
                  end
                  ST_WORD: begin
                     ptr_reg <= shift_in_reg[6:0];
                     sda_oe <= 1'b1;
                  end
                  ST_WDATA: begin
                     if (wr_cnt_reg < `SEBS_PAGE_BYTES) begin
                        pvalid_reg[ptr_reg[2:0]] <= 1'b1;
                        ptr_reg <= {ptr_reg[6:3], ptr_reg[2:0] + 3'h1};
                        wr_cnt_reg <= wr_cnt_reg + 4'h1;
                        sda_oe <= 1'b1;
                     end else begin
                        sda_oe <= 1'b0;
                     end
                  end
                  ST_RDATA: begin
                     sda_oe <= 1'b0;
                  end
                  default: begin
                     sda_oe <= 1'b0;
                  end
               endcase
            end else if (ack_end) begin
               in_ack_reg <= 1'b0;
               bit_cnt_reg <= `SEBS_BIT_RESET;
               sda_oe <= 1'b0;
               case (state_reg)
                  ST_DEV: state_reg <= rw_reg ? ST_RDATA : ST_WORD;
                  ST_WORD: state_reg <= ST_WDATA;
                  ST_WDATA: state_reg <= ST_WDATA;
                  ST_RDATA: begin
                     if (!master_ack_reg) begin
                        state_reg <= ST_IDLE;
                        fetch_en_reg <= 1'b0;
                     end
                  end
                  default: state_reg <= ST_IDLE;
               endcase
               if (tx_load) begin
                  // An empty buffer sends ones rather than stale data.
                  tx_shift_reg <= buf_out_valid ? buf_out_data : 8'hFF;
                  sda_oe <= buf_out_valid & ~buf_out_data[7];
                  ptr_reg <= ptr_reg + 7'h01;
               end
            end else if (scl_fall && state_reg == ST_RDATA && !in_ack_reg) begin
               sda_oe <= ~tx_shift_reg[7];
            end
         end
      end
   end
endmodule // sebs_top

/* File: sebs_checker.sv */
// Port checks for the serial EEPROM two-wire slave front end.
`timescale 1ns/1ps
module sebs_checker #(
   parameter [20:0] PROG_CYCLES = 21'h1E8480
) (
   // Clock and reset.
   input wire mclk,
   input wire resetn,
   // Watched pins.
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire legacy_tx_clock,
   input wire write_protect_n,
   input wire bidirectional_mode,
   input wire prog_busy
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   reg [20:0] busy_cnt_reg;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         busy_cnt_reg <= 21'h000000;
      else
         busy_cnt_reg <= prog_busy ? busy_cnt_reg + 21'h000001 : 21'h000000;
   end
   ////////////////////////////////////////////////////////////////////////////////
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   stable_high_a: assert property (bidirectional_mode && $past(bidirectional_mode)
      && scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("data moved with clock high");
   mode_sticky_a: assert property (bidirectional_mode |=> bidirectional_mode)
      else $error("mode fell back");
   mode_enter_a: assert property ($fell(scl_in) && !bidirectional_mode
      |-> ##[1:5] bidirectional_mode) else $error("mode not entered");
   busy_quiet_a: assert property (prog_busy |-> !sda_oe)
      else $error("driven while programming");
   busy_len_a: assert property ($fell(prog_busy) |-> busy_cnt_reg >= PROG_CYCLES - 1
      && busy_cnt_reg <= PROG_CYCLES + 1) else $error("programming length wrong");
   busy_stop_a: assert property ($rose(prog_busy) |-> scl_in && sda_in && write_protect_n)
      else $error("programming without stop");
   legacy_edge_a: assert property (!bidirectional_mode && scl_in && $changed(sda_oe)
      |-> legacy_tx_clock) else $error("bit moved without legacy clock");
endmodule // sebs_checker
bind sebs_top sebs_checker #(.PROG_CYCLES(PROG_CYCLES)) u_sebs_checker (
   .mclk(mclk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .legacy_tx_clock(legacy_tx_clock), .write_protect_n(write_protect_n),
   .bidirectional_mode(bidirectional_mode), .prog_busy(prog_busy));

/* File: sebs_i2c_host.sv */
// Behavioural two-wire bus master facing the slave front end.
`timescale 1ns/1ps
module sebs_i2c_host (
   // Clock.
   input wire mclk,
   // Bus.
   input wire sda,
   output reg scl,
   output reg sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Data moves one cycle after the clock falls, so the slave sees the fall first.
   task clk_bit(input logic b, output logic r);
      begin
         @(negedge mclk);
         sda_pull = !b;
         repeat (3) @(negedge mclk);
         scl = 1'b1;
         repeat (3) @(negedge mclk);
         r = sda;
         @(negedge mclk);
         scl = 1'b0;
      end
   endtask
   task start;
      begin
         @(negedge mclk);
         sda_pull = 1'b0;
         repeat (3) @(negedge mclk);
         scl = 1'b1;
         repeat (4) @(negedge mclk);
         sda_pull = 1'b1;
         repeat (4) @(negedge mclk);
         scl = 1'b0;
      end
   endtask
   task stop;
      begin
         @(negedge mclk);
         sda_pull = 1'b1;
         repeat (3) @(negedge mclk);
         scl = 1'b1;
         repeat (4) @(negedge mclk);
         sda_pull = 1'b0;
         repeat (4) @(negedge mclk);
      end
   endtask
   task pulse;
      begin
         @(negedge mclk);
         scl = 1'b0;
         repeat (4) @(negedge mclk);
         scl = 1'b1;
         repeat (4) @(negedge mclk);
      end
   endtask
   task wr(input logic [7:0] d, output logic ack);
      logic r;
      integer i;
      begin
         for (i = 7; i >= 0; i--) clk_bit(d[i], r);
         clk_bit(1'b1, r);
         ack = !r;
      end
   endtask
   task rd(output logic [7:0] d, input logic ack);
      logic r;
      integer i;
      begin
         for (i = 0; i < 8; i++) begin
            clk_bit(1'b1, r);
            d = {d[6:0], r};
         end
         clk_bit(!ack, r);
      end
   endtask
endmodule // sebs_i2c_host

/* File: tb_top.sv */
// Self-checking bench for the serial EEPROM two-wire slave front end.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
   localparam [20:0] PROG = 21'h12C;
   reg mclk;
   reg resetn;
   reg legacy_tx_clock;
   reg write_protect_n;
   wire scl;
   wire sda_pull;
   wire sda_out;
   wire sda_oe;
   wire bidirectional_mode;
   wire prog_busy;
   // Pull-up on the data wire; either party may pull it low.
   wire sda = !(sda_pull || (sda_oe && !sda_out));
   integer error_cnt = 0;
   integer checks = 0;
   integer i;
   integer j;
   reg ak;
   reg [7:0] d;
   reg [7:0] pg [0:7];
   sebs_top #(.PROG_CYCLES(PROG)) i_sebs_top (.mclk(mclk), .resetn(resetn), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .legacy_tx_clock(legacy_tx_clock),
      .write_protect_n(write_protect_n), .bidirectional_mode(bidirectional_mode),
      .prog_busy(prog_busy));
   sebs_i2c_host u_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks, error_cnt);
         if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task do_reset;
      begin
         resetn = 1'b0;
         repeat (16) @(negedge mclk);
         resetn = 1'b1;
         repeat (6) @(negedge mclk);
      end
   endtask
   task addr(input logic rw, input logic exp);
      begin
         u_host.start;
         u_host.wr({7'h50, rw}, ak);
         `CHK(ak, exp)
      end
   endtask
   task wait_idle;
      begin
         repeat (3) @(negedge mclk);
         for (j = 0; j < 1000 && prog_busy !== 1'b0; j++) @(negedge mclk);
         `CHK(prog_busy, 1'b0)
      end
   endtask
   task chk_read(input logic [2:0] a, input integer n);
      begin
         addr(1'b0, 1'b1);
         u_host.wr({5'h00, a}, ak);
         addr(1'b1, 1'b1);
         for (j = 0; j < n; j++) begin
            u_host.rd(d, j < n - 1);
            `CHK(d, pg[a + j[2:0]])
         end
         u_host.stop;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task t_page_write;
      begin
         u_host.pulse;
         addr(1'b0, 1'b1);
         u_host.wr(8'h80, ak);
         `CHK(ak, 1'b1)
         for (i = 0; i < 8; i++) begin
            pg[i] = 8'h5A ^ 8'(i * 37);
            u_host.wr(pg[i], ak);
            `CHK(ak, 1'b1)
         end
         u_host.wr(8'hEE, ak);
         `CHK(ak, 1'b0)
         `CHK(prog_busy, 1'b0)
         u_host.stop;
         repeat (3) @(negedge mclk);
         `CHK(prog_busy, 1'b1)
         addr(1'b0, 1'b0);
         u_host.stop;
         wait_idle;
         addr(1'b0, 1'b1);
         u_host.stop;
      end
   endtask
   task t_reads;
      begin
         addr(1'b1, 1'b1);
         u_host.rd(d, 1'b0);
         `CHK(d, pg[0])
         u_host.stop;
         chk_read(3'h5, 3);
         `CHK(prog_busy, 1'b0)
         for (i = 0; i < 3; i++) begin
            u_host.start;
            u_host.wr(i == 0 ? 8'hA2 : (i == 1 ? 8'h20 : 8'hE1), ak);
            `CHK(ak, 1'b0)
            u_host.stop;
         end
      end
   endtask
   task t_wrap_protect;
      begin
         addr(1'b0, 1'b1);
         u_host.wr(8'h06, ak);
         for (i = 0; i < 3; i++) begin
            pg[(6 + i) % 8] = 8'hC1 + 8'(i);
            u_host.wr(pg[(6 + i) % 8], ak);
         end
         u_host.stop;
         wait_idle;
         chk_read(3'h6, 2);
         chk_read(3'h0, 1);
         write_protect_n = 1'b0;
         addr(1'b0, 1'b1);
         u_host.wr(8'h02, ak);
         u_host.wr(8'h99, ak);
         `CHK(ak, 1'b1)
         u_host.stop;
         repeat (8) @(negedge mclk);
         `CHK(prog_busy, 1'b0)
         write_protect_n = 1'b1;
         chk_read(3'h2, 1);
      end
   endtask
   task t_legacy;
      begin
         do_reset;
         write_protect_n = 1'b0;
         for (i = 0; i < 18; i++) begin
            legacy_tx_clock = 1'b1;
            repeat (4) @(negedge mclk);
            `CHK(sda, (i % 9 == 8) ? 1'b1 : pg[i / 9][7 - i % 9])
            legacy_tx_clock = 1'b0;
            repeat (4) @(negedge mclk);
         end
         write_protect_n = 1'b1;
         u_host.pulse;
         `CHK(bidirectional_mode, 1'b1)
         legacy_tx_clock = 1'b1;
         repeat (4) @(negedge mclk);
         `CHK(sda, 1'b1)
         legacy_tx_clock = 1'b0;
         repeat (4) @(negedge mclk);
         `CHK(bidirectional_mode, 1'b1)
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = !mclk;
   end
   initial begin
      resetn = 1'b0;
      legacy_tx_clock = 1'b0;
      write_protect_n = 1'b1;
      do_reset;
      t_page_write;
      t_reads;
      t_wrap_protect;
      t_legacy;
      wrap_up;
   end
   // The whole run needs well under 15000 cycles; a limit of 40000 leaves margin.
   initial begin
      #400000;
      error_cnt++;
      wrap_up;
   end
endmodule // tb_top
